// >>> design/mas_sequencer.sv
// Control logic of a multi-channel 12-bit sampling converter with serial port.
// Assumes shift clock and selects are synchronous to ref_clk and slower than it;
// the analog comparator decision arrives on compHigh once per conversion step.
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer (
  input  wire logic                          ref_clk,             // System clock, 10 MHz
  input  wire logic                          rst_n,               // Asynchronous reset, low
  input  wire logic                          shiftClk,            // Serial shift clock from host
  input  wire logic                          mux_select_n,        // Mux select, low active
  input  wire logic                          converter_select_n,  // Converter select, low active
  input  wire logic                          dataIn,              // Serial data input
  input  wire logic                          compHigh,            // Comparator decision for trial bit
  output logic                               dataOut,             // Serial data output
  output logic                               dataOutEn,           // High while output drives
  output logic [mas_pkg::CHAN_COUNT-1:0]     chanOn,              // One-hot channel switches
  output logic [mas_pkg::ADDR_BITS-1:0]      chanAddr,            // Loaded channel address
  output logic                               chanEnable,          // Loaded enable bit
  output logic                               sampling,            // Sample switch closed
  output logic                               converterPowered,    // Converter supply on
  output logic                               comparatorPowered,   // Comparator and bias on
  output logic [mas_pkg::RES_BITS-1:0]       trialWord,           // DAC trial word for comparator
  output logic                               convDone             // One-cycle pulse at result
);
  import mas_pkg::*;

  mas_state_e                state;
  mas_state_e                next_state;
  logic                      clkPrev;
  logic [CMD_BITS-1:0]       shiftReg;
  logic [CMD_BITS-1:0]       next_shiftReg;
  logic [CMD_BITS-1:0]       cmdWord;
  logic [CMD_BITS-1:0]       next_cmdWord;
  logic                      muxSelPrev;
  logic [5:0]                fallCnt;
  logic [5:0]                next_fallCnt;
  logic [3:0]                bitIdx;
  logic [3:0]                next_bitIdx;
  logic [RES_BITS-1:0]       sar;
  logic [RES_BITS-1:0]       next_sar;
  logic [RES_BITS-1:0]       trial;
  logic [RES_BITS-1:0]       next_trial;
  logic                      next_dataOut;
  logic                      outDrive;
  logic                      next_outDrive;
  logic                      next_convDone;
  logic                      memBit;
  logic                      memWr;
  logic [3:0]                memIdx;
  logic                      riseEdge;
  logic                      fallEdge;

  // Decodes the loaded word into one-hot switch controls
  function automatic logic [CHAN_COUNT-1:0] chanDecode(input logic [CMD_BITS-1:0] w);
    logic [CHAN_COUNT-1:0] d;
    d = CHAN_OFF;
    if (w[EN_POS]) begin
      d[w[ADDR_BITS-1:0]] = 1'b1;
    end
    return d;
  endfunction

  // Edges of the sampled shift clock
  assign riseEdge = shiftClk & ~clkPrev;
  assign fallEdge = ~shiftClk & clkPrev;

  // Mux side: shift while its select is high, latch on its falling edge
  always_comb begin
    next_shiftReg = shiftReg;
    next_cmdWord  = cmdWord;
    if (mux_select_n && riseEdge) begin
      next_shiftReg = {shiftReg[CMD_BITS-2:0], dataIn};
    end
    if (muxSelPrev && !mux_select_n) begin
      next_cmdWord = shiftReg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev    <= 1'b0;
      muxSelPrev <= 1'b1;
      shiftReg   <= CMD_RESET;
      cmdWord    <= CMD_RESET;
    end else begin
      clkPrev    <= shiftClk;
      muxSelPrev <= mux_select_n;
      shiftReg   <= next_shiftReg;
      cmdWord    <= next_cmdWord;
    end
  end

  // Word stays on the switches while mux select is low; a reload changes it
  assign chanOn     = mux_select_n ? CHAN_OFF : chanDecode(cmdWord);
  assign chanAddr   = cmdWord[ADDR_BITS-1:0];
  assign chanEnable = cmdWord[EN_POS];

  // Converter sequence; select high returns state, edge count and data output to idle; trial, result and bit index keep their values
  always_comb begin
    next_state     = state;
    next_fallCnt   = fallCnt;
    next_bitIdx    = bitIdx;
    next_sar       = sar;
    next_trial     = trial;
    next_dataOut   = dataOut;
    next_outDrive  = outDrive;
    next_convDone  = 1'b0;
    memWr          = 1'b0;
    memIdx         = bitIdx;
    if (converter_select_n) begin
      next_state     = MAS_IDLE;
      next_fallCnt   = 6'h00;
      next_outDrive  = 1'b0;
      next_dataOut   = 1'b0;
    end else begin
      if (fallEdge && fallCnt != EDGE_MAX) begin
        next_fallCnt = fallCnt + 6'h01;
      end
      case (state)
        MAS_IDLE: begin
          next_state = MAS_SAMPLE;
        end
        MAS_SAMPLE: begin
          if (fallEdge) begin
            if (fallCnt + 6'h01 == 6'(DRIVE_EDGE)) begin
              next_outDrive  = 1'b1;
              next_dataOut   = 1'b0;
            end
            if (fallCnt + 6'h01 == 6'(HOLD_EDGE)) begin
              next_state  = MAS_CONV;
              next_bitIdx = 4'(RES_BITS - 1);
              next_sar    = RESULT_RESET;
              next_trial  = 12'h800;
              next_dataOut = 1'b0;
            end
          end
        end
        MAS_CONV: begin
          // One decision per shift clock, bit out as soon as it is known
          if (fallEdge) begin
            next_sar    = compHigh ? trial : (trial & ~(12'h001 << bitIdx));
            next_dataOut = compHigh;
            if (bitIdx == 4'h0) begin
              next_state = MAS_LSB;
              next_bitIdx = 4'h1;
              next_convDone = 1'b1;
              memWr = 1'b1;
            end else begin
              next_bitIdx = bitIdx - 4'h1;
              next_trial = (compHigh ? trial : (trial & ~(12'h001 << bitIdx))) | (12'h001 << (bitIdx - 4'h1));
            end
          end
        end
        MAS_MSB: begin
          next_state = MAS_LSB;
        end
        MAS_LSB: begin
          // LSB first replay from the stored word; LSB itself was just sent
          memIdx = bitIdx;
          if (fallEdge) begin
            next_dataOut = memBit;
            if (bitIdx == 4'(RES_BITS - 1)) begin
              next_state = MAS_ZERO;
            end else begin
              next_bitIdx = bitIdx + 4'h1;
            end
          end
        end
        default: begin
          if (fallEdge) begin
            next_dataOut = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state     <= MAS_IDLE;
      fallCnt   <= 6'h00;
      bitIdx    <= 4'h0;
      sar       <= RESULT_RESET;
      trial     <= RESULT_RESET;
      dataOut   <= 1'b0;
      outDrive  <= 1'b0;
      convDone  <= 1'b0;
    end else begin
      state     <= next_state;
      fallCnt   <= next_fallCnt;
      bitIdx    <= next_bitIdx;
      sar       <= next_sar;
      trial     <= next_trial;
      dataOut   <= next_dataOut;
      outDrive  <= next_outDrive;
      convDone  <= next_convDone;
    end
  end

  // Last decided bit folded in so the stored word is complete
  mas_result_mem u_mem (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .wrEn    (memWr),
    .wrData  (compHigh ? trial : (trial & 12'hffe)),
    .rdIdx   (memIdx),
    .rdBit   (memBit)
  );

  // Power and analog controls; comparator off once the result is complete
  assign sampling          = (state == MAS_SAMPLE) && !converter_select_n;
  assign converterPowered  = !converter_select_n;
  assign comparatorPowered = !converter_select_n && (state == MAS_SAMPLE || state == MAS_CONV);
  assign trialWord         = trial;
  // Drive gated by the select itself so the wire floats in the very cycle the select rises
  assign dataOutEn         = outDrive && !converter_select_n;
endmodule
`default_nettype wire

// >>> design/mas_pkg.sv
// Constants of the multiplexed converter serial sequencer.
// Assumes a single 10 MHz system clock; the shift clock arrives as a sampled input.
package mas_pkg;
  localparam int          CLK_PERIOD_NS   = 100;          // System clock period
  localparam int          CMD_BITS        = 4;            // Enable bit plus three address bits
  localparam int          ADDR_BITS       = 3;            // Channel address width
  localparam int          CHAN_COUNT      = 8;            // Channels of the wide variant
  localparam int          RES_BITS        = 12;           // Converter resolution
  localparam int          EN_POS          = 3;            // Enable bit position in the word
  localparam int          HOLD_EDGE       = 2;            // Falling edge that starts hold
  localparam int          DRIVE_EDGE      = 1;            // Falling edge that starts driving data
  localparam int          CONV_CYCLES     = 12;           // Shift clocks per conversion
  localparam logic [7:0]  CHAN_OFF        = 8'h00;        // All channels off
  localparam logic [3:0]  CMD_RESET       = 4'h0;         // Word after reset: disabled
  localparam logic [11:0] RESULT_RESET    = 12'h000;      // Result after reset
  localparam logic [5:0]  EDGE_MAX        = 6'h3f;        // Saturation of the edge counter

  typedef enum logic [2:0] {
    MAS_IDLE   = 3'b000,
    MAS_SAMPLE = 3'b001,
    MAS_CONV   = 3'b010,
    MAS_MSB    = 3'b011,
    MAS_LSB    = 3'b100,
    MAS_ZERO   = 3'b101
  } mas_state_e;
endpackage

// >>> design/mas_result_mem.sv
// Result store: holds the last converted word; read data leave a register.
// Assumes a write and a bit read never need the same cycle's new word.
`timescale 1ns/1ps
`default_nettype none
module mas_result_mem (
  input  wire logic                      ref_clk,  // System clock
  input  wire logic                      rst_n,    // Asynchronous reset, low
  input  wire logic                      wrEn,     // Store a new result
  input  wire logic [mas_pkg::RES_BITS-1:0] wrData, // Result to store
  input  wire logic [3:0]                rdIdx,    // Bit to read
  output logic                           rdBit     // Registered bit
);
  import mas_pkg::*;
  logic [RES_BITS-1:0] word;
  logic [RES_BITS-1:0] next_word;
  logic                next_rdBit;

  // Word update and bit select
  always_comb begin
    next_word  = wrEn ? wrData : word;
    next_rdBit = (rdIdx < 4'(RES_BITS)) ? word[rdIdx] : 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      word  <= RESULT_RESET;
      rdBit <= 1'b0;
    end else begin
      word  <= next_word;
      rdBit <= next_rdBit;
    end
  end
endmodule
`default_nettype wire

// >>> verification/mas_sequencer_asserts.sv
// Port checker for the sequencer, bound into every mas_sequencer.
// Assumes shiftClk is slower than a quarter of ref_clk and selects change off its edges.
`timescale 1ns/1ps
`default_nettype none
module mas_sequencer_asserts (
  input  wire logic       ref_clk,             // System clock
  input  wire logic       rst_n,               // Reset, low
  input  wire logic       shiftClk,            // Host shift clock
  input  wire logic       mux_select_n,        // Mux select
  input  wire logic       converter_select_n,  // Converter select
  input  wire logic       dataOutEn,           // Output drive
  input  wire logic [7:0] chanOn,              // Channel switches
  input  wire logic [2:0] chanAddr,            // Loaded address
  input  wire logic       chanEnable,          // Loaded enable
  input  wire logic       sampling,            // Sample switch
  input  wire logic       converterPowered,    // Converter supply
  input  wire logic       comparatorPowered,   // Comparator supply
  input  wire logic       convDone             // Result pulse
);
  logic       clkPrev;       // Shift clock one cycle ago
  logic [4:0] fallCnt;       // Falls since converter select fell; saturates so long frames stay quiet
  logic [4:0] next_fallCnt;  // Next count
  // Count shift falls inside a frame
  always_comb begin
    next_fallCnt = fallCnt;
    if (converter_select_n) next_fallCnt = 5'h00;
    else if (clkPrev && !shiftClk && fallCnt != 5'h1f) next_fallCnt = fallCnt + 5'h01;
  end
  // Register only
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clkPrev <= 1'b0;
      fallCnt <= 5'h00;
    end else begin
      clkPrev <= shiftClk;
      fallCnt <= next_fallCnt;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  idle_power_off_a: assert property (converter_select_n |-> !converterPowered && !dataOutEn)
    else $error("converter active with select high");
  drive_start_a: assert property (!converter_select_n && fallCnt >= 5'h02 |-> dataOutEn)
    else $error("data wire not driven in time");
  sample_phase_a: assert property (fallCnt == 5'h01 |-> sampling)
    else $error("hold entered before second fall");
  hold_start_a: assert property (fallCnt >= 5'h03 |-> !sampling)
    else $error("still sampling after second fall");
  conv_length_a: assert property (convDone |-> fallCnt == 5'h0e)
    else $error("conversion not twelve shift clocks");
  comp_off_a: assert property (fallCnt >= 5'h0f |-> !comparatorPowered)
    else $error("comparator powered after conversion");
  chan_off_a: assert property (!chanEnable || mux_select_n |-> chanOn == 8'h00)
    else $error("channel on while disabled");
  chan_pick_a: assert property (!mux_select_n && chanEnable |-> chanOn == (8'h01 << chanAddr))
    else $error("wrong channel switched on");
  word_hold_a: assert property (!mux_select_n && !$past(mux_select_n) && !$past(mux_select_n, 2)
    |-> $stable(chanAddr) && $stable(chanEnable))
    else $error("channel word changed while mux selected");
  cover property (convDone);
  cover property (chanOn != 8'h00);
  cover property (dataOutEn && fallCnt == 5'h18);
endmodule
bind mas_sequencer mas_sequencer_asserts mas_sequencer_asserts_inst (.ref_clk, .rst_n, .shiftClk, .mux_select_n,
  .converter_select_n, .dataOutEn, .chanOn, .chanAddr, .chanEnable, .sampling, .converterPowered,
  .comparatorPowered, .convDone);
`default_nettype wire

// >>> verification/mas_host_model.sv
// Host serial port model: shift clock, both selects and the shared data wire.
// Assumes ref_clk drives it; shift clock is one eighth of ref_clk and stands low outside frames.
`timescale 1ns/1ps
`default_nettype none
module mas_host_model (
  input  wire logic ref_clk,             // System clock
  input  wire logic dataOut,             // Device data out
  input  wire logic dataOutEn,           // Device drive enable
  output logic      shiftClk,            // Shift clock
  output logic      mux_select_n,        // Mux select
  output logic      converter_select_n,  // Converter select
  output logic      dataWire             // Resolved shared wire
);
  logic hostBit = 1'b0;   // Bit launched by the host
  logic floatBit = 1'b0;  // Undriven wire toggles so a stale value never passes
  initial {shiftClk, mux_select_n, converter_select_n} = 3'b011;
  always @(negedge ref_clk) floatBit <= ~floatBit;
  // Host releases the wire whenever converter select is low
  always_comb dataWire = converter_select_n ? hostBit : (dataOutEn ? dataOut : floatBit);
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // Mode 0 tied selects, 1 mux load only, 2 converter only; bits launch on falls, sampled on rises
  task automatic frame(input logic [7:0] w, input int mode, output logic [25:0] rx);
    rx = '0;
    if (mode != 2) mux_select_n = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      if (mode != 2) hostBit = w[i];
      tick(4);
      shiftClk = 1'b1;
      tick(2);
      if (i > 0) tick(2);
      if (i > 0) shiftClk = 1'b0;
    end
    if (mode != 2) mux_select_n = 1'b0;
    if (mode != 1) converter_select_n = 1'b0;
    tick(2);
    for (int k = 0; k < 26 && mode != 1; k++) begin
      shiftClk = 1'b0;
      tick(4);
      rx[k] = dataWire;
      shiftClk = 1'b1;
      tick(4);
    end
    shiftClk = 1'b0;
    tick(4);
    converter_select_n = 1'b1;
    if (mode == 0) mux_select_n = 1'b1;
    tick(4);
  endtask
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench: host model frames against the sequencer, result checked as a whole word MSB first and as bits 11 to 1 LSB first.
// Assumes the comparator is an ideal code compare against the trial word.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mas_pkg::*;
  logic ref_clk = 1'b0;  logic rst_n = 1'b0;  logic compHigh = 1'b0;  logic [11:0] vin = 12'h000;
  logic shiftClk, mux_select_n, converter_select_n, dataWire, dataOut, dataOutEn, chanEnable;
  logic sampling, converterPowered, comparatorPowered, convDone;
  logic [7:0] chanOn;  logic [2:0] chanAddr;  logic [11:0] trialWord;  logic [25:0] junk;
  int err_total = 0;  int checks_done = 0;
  logic [11:0] vals [8] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'h5a3, 12'ha5c, 12'h001, 12'hffe};
  always #50 ref_clk = ~ref_clk;
  // Ideal comparator: high while the held code reaches the trial word
  always @(negedge ref_clk) compHigh <= (vin >= trialWord);
  mas_sequencer mas_sequencer_inst (.ref_clk(ref_clk), .rst_n(rst_n), .shiftClk(shiftClk),
    .mux_select_n(mux_select_n), .converter_select_n(converter_select_n), .dataIn(dataWire),
    .compHigh(compHigh), .dataOut(dataOut), .dataOutEn(dataOutEn), .chanOn(chanOn), .chanAddr(chanAddr),
    .chanEnable(chanEnable), .sampling(sampling), .converterPowered(converterPowered),
    .comparatorPowered(comparatorPowered), .trialWord(trialWord), .convDone(convDone));
  mas_host_model mas_host_model_inst (.ref_clk(ref_clk), .dataOut(dataOut), .dataOutEn(dataOutEn),
    .shiftClk(shiftClk), .mux_select_n(mux_select_n), .converter_select_n(converter_select_n),
    .dataWire(dataWire));
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One conversion frame; the word is read back MSB first, then LSB first, framed by zeros
  task automatic convert(input logic [7:0] w, input int mode, input logic [11:0] v);
    logic [25:0] rx;
    logic [11:0] msb;
    vin = v;
    mas_host_model_inst.frame(w, mode, rx);
    for (int k = 0; k < 12; k++) msb[11 - k] = rx[2 + k];
    check(msb, v);
    check({1'b0, rx[24:14]}, {1'b0, v[11:1]});
    check({10'h000, rx[25], rx[1]}, 12'h000);
  endtask
  task automatic conclude();
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk) rst_n = 1'b1;
    repeat (2) @(negedge ref_clk);
    check({4'h0, chanOn}, 12'h000);
    // Load each channel once by mux select, then convert by converter select alone
    for (int c = 0; c < 8; c++) begin
      mas_host_model_inst.frame({4'ha, 1'b1, c[2:0]}, 1, junk);
      check({4'h0, chanOn}, 12'h001 << c);
      check({8'h00, chanEnable, chanAddr}, {8'h00, 1'b1, c[2:0]});
      convert(8'h00, 2, vals[c]);
      check({4'h0, chanOn}, 12'h001 << c);
    end
    mas_host_model_inst.frame({4'hf, 1'b0, 3'h5}, 1, junk);
    check({3'h0, chanOn, chanEnable}, 12'h000);
    // Tied selects on the shared wire; extra leading bits must be dropped
    convert({4'h9, 1'b1, 3'h6}, 0, 12'h3c5);
    check({8'h00, chanEnable, chanAddr}, {8'h00, 1'b1, 3'h6});
    check({11'h000, converterPowered}, 12'h000);
    conclude();
  end
endmodule
`default_nettype wire
